// ---- design/sbmc_consts.svh ----
/*
 * Register map, field positions, reset values and timing counts of the
 * serial bus mode-control block.
 * Assumes a 25 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
`ifndef SBMC_CONSTS_SVH
`define SBMC_CONSTS_SVH

// byte addresses
`define SBMC_ADDR_MODE    32'h0000_0000
`define SBMC_ADDR_CTRL    32'h0000_0004
`define SBMC_ADDR_TXD     32'h0000_0008
`define SBMC_ADDR_STAT    32'h0000_000c

// mode register fields
`define SBMC_MODE_ORDER   7
`define SBMC_MODE_WAIT    6
`define SBMC_MODE_PROT    3
`define SBMC_MODE_RSV     2'h3
`define SBMC_MODE_RST     8'h38

// control register fields
`define SBMC_CTRL_SYNC    0
`define SBMC_CTRL_MASTER  1
`define SBMC_CTRL_START   2
`define SBMC_CTRL_ACKLOW  3
`define SBMC_TXD_RST      8'hff

// bus responses
`define SBMC_RESP_OKAY    2'h0
`define SBMC_RESP_SLVERR  2'h2

// timing: transfer clock derived from the system clock
`define SBMC_CLK_NS       40
`define SBMC_TCLK_NS      320
`define SBMC_TCLK_CYC     (`SBMC_TCLK_NS / `SBMC_CLK_NS)
`define SBMC_HALF_CYC     (`SBMC_TCLK_CYC / 2)
`define SBMC_WAIT_CYC     (2 * `SBMC_TCLK_CYC)

`endif

// ---- design/sbmc_pin_sync.sv ----
/*
 * Two-flop synchroniser with edge detection for one serial pin.
 * Assumes the pin is asynchronous to clk_in.
 */
`timescale 1ns/1ps
module sbmc_pin_sync (
	// clock and reset
	input  wire logic clk_in,
	input  wire logic rst_in,
	// pin
	input  wire logic pin_in,
	// synchronised level and edges
	output logic      level_out,
	output logic      rise_out,
	output logic      fall_out
);

	logic meta_q;
	logic prev_q;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			meta_q    <= 1'b1;
			level_out <= 1'b1;
			prev_q    <= 1'b1;
		end else begin
			meta_q    <= pin_in;
			level_out <= meta_q;
			prev_q    <= level_out;
		end
	end

	assign rise_out = level_out & ~prev_q;
	assign fall_out = ~level_out & prev_q;

endmodule : sbmc_pin_sync

// ---- design/sbmc_pkg.sv ----
/*
 * Types shared by the serial bus mode-control design.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package sbmc_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_LOW,
		ST_HIGH,
		ST_WAIT,
		ST_SLV
	} sbmc_state_e;

endpackage : sbmc_pkg

// ---- design/sbmc_top.sv ----
/*
 * Serial bus mode control: mode register, bit counter and a frame engine
 * that shifts one frame over open-drain clock and data pins.
 * Assumes an AXI4-Lite master on CLK_IN and a pulled-up two-wire bus or a
 * clocked synchronous partner on the pins.
 */
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "sbmc_consts.svh"
module sbmc_top (
	// clock and reset
	input  wire logic        CLK_IN,
	input  wire logic        RST_IN,
	// axi4-lite write address
	input  wire logic [31:0] AXI_AWADDR_IN,
	input  wire logic        AXI_AWVALID_IN,
	output logic             AXI_AWREADY_OUT,
	// axi4-lite write data
	input  wire logic [31:0] AXI_WDATA_IN,
	input  wire logic [3:0]  AXI_WSTRB_IN,
	input  wire logic        AXI_WVALID_IN,
	output logic             AXI_WREADY_OUT,
	// axi4-lite write response
	output logic [1:0]       AXI_BRESP_OUT,
	output logic             AXI_BVALID_OUT,
	input  wire logic        AXI_BREADY_IN,
	// axi4-lite read address
	input  wire logic [31:0] AXI_ARADDR_IN,
	input  wire logic        AXI_ARVALID_IN,
	output logic             AXI_ARREADY_OUT,
	// axi4-lite read data
	output logic [31:0]      AXI_RDATA_OUT,
	output logic [1:0]       AXI_RRESP_OUT,
	output logic             AXI_RVALID_OUT,
	input  wire logic        AXI_RREADY_IN,
	// serial clock pin
	input  wire logic        SCL_IN,
	output logic             SCL_OUT,
	output logic             SCL_OE_N_OUT,
	// serial data pin
	input  wire logic        SDA_IN,
	output logic             SDA_OUT,
	output logic             SDA_OE_N_OUT
);

	// reset image of the mode register; a literal cannot be bit-selected directly
	localparam logic [7:0]   mode_rst = `SBMC_MODE_RST;
	// registers
	logic                    order_q;
	logic                    wait_q;
	logic [2:0]              cnt_q;
	logic                    sync_q;
	logic                    master_q;
	logic                    acklow_q;
	logic [7:0]              txd_q;
	logic                    start_q;
	// axi state
	logic                    aw_have_q;
	logic [31:0]             aw_addr_q;
	logic                    w_have_q;
	logic [31:0]             w_data_q;
	logic [3:0]              w_strb_q;
	logic                    wr_fire;
	// engine
	sbmc_pkg::sbmc_state_e   state_q;
	logic [4:0]              tmr_q;
	logic [3:0]              left_q;
	logic [7:0]              sh_q;
	logic [7:0]              rx_q;
	logic                    ack_q;
	logic                    scl_low_q;
	logic                    sda_low_q;
	logic                    done_q;
	logic                    busy;
	// pins
	logic                    scl_lvl;
	logic                    scl_rise;
	logic                    scl_fall;
	logic                    sda_lvl;

	function automatic logic [3:0] frame_len(input logic [2:0] c, input logic s);
		if (s) begin
			frame_len = (c == 3'h0) ? 4'h8 : {1'b0, c};
		end else begin
			frame_len = (c == 3'h0) ? 4'h9 : {1'b0, c} + 4'h1;
		end
	endfunction : frame_len

	function automatic logic [2:0] left_code(input logic [3:0] r, input logic s);
		logic [3:0] t;
		t = r - 4'h1;
		left_code = s ? r[2:0] : t[2:0];
	endfunction : left_code

	function automatic logic [7:0] shift_out(input logic [7:0] v, input logic lsb);
		shift_out = lsb ? {1'b1, v[7:1]} : {v[6:0], 1'b1};
	endfunction : shift_out

	function automatic logic [7:0] shift_in(input logic [7:0] v, input logic lsb,
	                                         input logic b);
		shift_in = lsb ? {b, v[7:1]} : {v[6:0], b};
	endfunction : shift_in

	// open-drain: a 0 bit pulls low; in two-wire format the last bit is the ack
	function automatic logic drive_low(input logic [7:0] v, input logic [3:0] l);
		if (!sync_q && l == 4'h1) begin
			drive_low = acklow_q;
		end else begin
			drive_low = order_q ? ~v[0] : ~v[7];
		end
	endfunction : drive_low

	function automatic logic addr_hit(input logic [31:0] a);
		addr_hit = (a == `SBMC_ADDR_MODE) || (a == `SBMC_ADDR_CTRL) ||
		           (a == `SBMC_ADDR_TXD) || (a == `SBMC_ADDR_STAT);
	endfunction : addr_hit

	function automatic logic [31:0] rd_word(input logic [31:0] a);
		rd_word = 32'h0000_0000;
		case (a)
			`SBMC_ADDR_MODE: begin
				rd_word[7:0] = {order_q, wait_q, `SBMC_MODE_RSV, 1'b1,
				                busy ? left_code(left_q, sync_q) : cnt_q};
			end
			`SBMC_ADDR_CTRL: begin
				rd_word[3:0] = {acklow_q, 1'b0, master_q, sync_q};
			end
			`SBMC_ADDR_TXD: begin
				rd_word[7:0] = txd_q;
			end
			`SBMC_ADDR_STAT: begin
				rd_word[9:0] = {ack_q, busy, rx_q};
			end
			default: begin
				rd_word = 32'h0000_0000;
			end
		endcase
	endfunction : rd_word

	sbmc_pin_sync u_scl_sync (
		.clk_in    (CLK_IN),
		.rst_in    (RST_IN),
		.pin_in    (SCL_IN),
		.level_out (scl_lvl),
		.rise_out  (scl_rise),
		.fall_out  (scl_fall)
	);

	sbmc_pin_sync u_sda_sync (
		.clk_in    (CLK_IN),
		.rst_in    (RST_IN),
		.pin_in    (SDA_IN),
		.level_out (sda_lvl),
		.rise_out  (),
		.fall_out  ()
	);

	assign busy    = (state_q != sbmc_pkg::ST_IDLE);
	assign wr_fire = aw_have_q && w_have_q && !AXI_BVALID_OUT;

	// write address and data are taken independently, in either order
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			aw_have_q       <= 1'b0;
			aw_addr_q       <= 32'h0000_0000;
			AXI_AWREADY_OUT <= 1'b1;
		end else if (AXI_AWVALID_IN && AXI_AWREADY_OUT) begin
			aw_have_q       <= 1'b1;
			aw_addr_q       <= AXI_AWADDR_IN;
			AXI_AWREADY_OUT <= 1'b0;
		end else if (wr_fire) begin
			aw_have_q       <= 1'b0;
			AXI_AWREADY_OUT <= 1'b1;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			w_have_q       <= 1'b0;
			w_data_q       <= 32'h0000_0000;
			w_strb_q       <= 4'h0;
			AXI_WREADY_OUT <= 1'b1;
		end else if (AXI_WVALID_IN && AXI_WREADY_OUT) begin
			w_have_q       <= 1'b1;
			w_data_q       <= AXI_WDATA_IN;
			w_strb_q       <= AXI_WSTRB_IN;
			AXI_WREADY_OUT <= 1'b0;
		end else if (wr_fire) begin
			w_have_q       <= 1'b0;
			AXI_WREADY_OUT <= 1'b1;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			AXI_BVALID_OUT <= 1'b0;
			AXI_BRESP_OUT  <= `SBMC_RESP_OKAY;
		end else if (wr_fire) begin
			AXI_BVALID_OUT <= 1'b1;
			AXI_BRESP_OUT  <= addr_hit(aw_addr_q) ? `SBMC_RESP_OKAY : `SBMC_RESP_SLVERR;
		end else if (AXI_BREADY_IN) begin
			AXI_BVALID_OUT <= 1'b0;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			AXI_ARREADY_OUT <= 1'b1;
			AXI_RVALID_OUT  <= 1'b0;
			AXI_RDATA_OUT   <= 32'h0000_0000;
			AXI_RRESP_OUT   <= `SBMC_RESP_OKAY;
		end else if (AXI_ARVALID_IN && AXI_ARREADY_OUT) begin
			AXI_ARREADY_OUT <= 1'b0;
			AXI_RVALID_OUT  <= 1'b1;
			AXI_RDATA_OUT   <= rd_word(AXI_ARADDR_IN);
			AXI_RRESP_OUT   <= addr_hit(AXI_ARADDR_IN) ? `SBMC_RESP_OKAY : `SBMC_RESP_SLVERR;
		end else if (AXI_RVALID_OUT && AXI_RREADY_IN) begin
			AXI_ARREADY_OUT <= 1'b1;
			AXI_RVALID_OUT  <= 1'b0;
		end
	end

	// mode register; a count write in the cycle after the frame ends beats the clear
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			order_q <= mode_rst[`SBMC_MODE_ORDER];
			wait_q  <= mode_rst[`SBMC_MODE_WAIT];
			cnt_q   <= mode_rst[2:0];
		end else begin
			if (done_q) begin
				cnt_q <= 3'h0;
			end
			if (wr_fire && aw_addr_q == `SBMC_ADDR_MODE && w_strb_q[0]) begin
				order_q <= w_data_q[`SBMC_MODE_ORDER];
				wait_q  <= w_data_q[`SBMC_MODE_WAIT];
				if (!w_data_q[`SBMC_MODE_PROT]) begin
					cnt_q <= w_data_q[2:0];
				end
			end
		end
	end

	// control and transmit data; start only takes effect while idle
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			sync_q   <= 1'b0;
			master_q <= 1'b0;
			acklow_q <= 1'b0;
			txd_q    <= `SBMC_TXD_RST;
			start_q  <= 1'b0;
		end else begin
			start_q <= 1'b0;
			if (wr_fire && w_strb_q[0] && aw_addr_q == `SBMC_ADDR_CTRL) begin
				sync_q   <= w_data_q[`SBMC_CTRL_SYNC];
				master_q <= w_data_q[`SBMC_CTRL_MASTER];
				acklow_q <= w_data_q[`SBMC_CTRL_ACKLOW];
				start_q  <= w_data_q[`SBMC_CTRL_START] && !busy;
			end
			if (wr_fire && w_strb_q[0] && aw_addr_q == `SBMC_ADDR_TXD) begin
				txd_q <= w_data_q[7:0];
			end
		end
	end

	// frame engine: master paces its own clock, slave follows pin edges
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			state_q   <= sbmc_pkg::ST_IDLE;
			tmr_q     <= 5'h00;
			left_q    <= 4'h0;
			sh_q      <= 8'hff;
			rx_q      <= 8'h00;
			ack_q     <= 1'b1;
			scl_low_q <= 1'b0;
			sda_low_q <= 1'b0;
			done_q    <= 1'b0;
		end else begin
			done_q <= 1'b0;
			case (state_q)
				sbmc_pkg::ST_IDLE: begin
					if (start_q) begin
						left_q    <= frame_len(cnt_q, sync_q);
						sh_q      <= txd_q;
						sda_low_q <= drive_low(txd_q, frame_len(cnt_q, sync_q));
						tmr_q     <= 5'(`SBMC_HALF_CYC - 1);
						scl_low_q <= master_q;
						state_q   <= master_q ? sbmc_pkg::ST_LOW : sbmc_pkg::ST_SLV;
					end
				end
				sbmc_pkg::ST_LOW: begin
					if (tmr_q == 5'h00) begin
						scl_low_q <= 1'b0;
						tmr_q     <= 5'(`SBMC_HALF_CYC - 1);
						state_q   <= sbmc_pkg::ST_HIGH;
					end else begin
						tmr_q <= tmr_q - 5'h01;
					end
				end
				sbmc_pkg::ST_HIGH: begin
					// the timer holds while a slave stretches the clock low
					if (scl_lvl && tmr_q != 5'h00) begin
						tmr_q <= tmr_q - 5'h01;
					end else if (scl_lvl) begin
						if (!sync_q && left_q == 4'h1) begin
							ack_q <= sda_lvl;
						end else begin
							rx_q <= shift_in(rx_q, order_q, sda_lvl);
						end
						left_q <= left_q - 4'h1;
						if (left_q == 4'h1) begin
							sda_low_q <= 1'b0;
							done_q    <= 1'b1;
							state_q   <= sbmc_pkg::ST_IDLE;
						end else begin
							sh_q      <= shift_out(sh_q, order_q);
							scl_low_q <= 1'b1;
							if (wait_q && !sync_q && left_q == 4'h2) begin
								tmr_q   <= 5'(`SBMC_WAIT_CYC - 1);
								state_q <= sbmc_pkg::ST_WAIT;
							end else begin
								sda_low_q <= drive_low(shift_out(sh_q, order_q),
								                       left_q - 4'h1);
								tmr_q     <= 5'(`SBMC_HALF_CYC - 1);
								state_q   <= sbmc_pkg::ST_LOW;
							end
						end
					end
				end
				sbmc_pkg::ST_WAIT: begin
					// data line keeps the last bit until the ack slot opens
					if (tmr_q == 5'h00) begin
						sda_low_q <= drive_low(sh_q, left_q);
						tmr_q     <= 5'(`SBMC_HALF_CYC - 1);
						state_q   <= sbmc_pkg::ST_LOW;
					end else begin
						tmr_q <= tmr_q - 5'h01;
					end
				end
				sbmc_pkg::ST_SLV: begin
					// slave timing comes from the partner; wait setting unused
					if (scl_rise) begin
						if (!sync_q && left_q == 4'h1) begin
							ack_q <= sda_lvl;
						end else begin
							rx_q <= shift_in(rx_q, order_q, sda_lvl);
						end
						sh_q   <= shift_out(sh_q, order_q);
						left_q <= left_q - 4'h1;
						if (left_q == 4'h1) begin
							done_q  <= 1'b1;
							state_q <= sbmc_pkg::ST_IDLE;
						end
					end else if (scl_fall) begin
						sda_low_q <= drive_low(sh_q, left_q);
					end
				end
				default: begin
					state_q <= sbmc_pkg::ST_IDLE;
				end
			endcase
			if (state_q == sbmc_pkg::ST_SLV && scl_rise && left_q == 4'h1) begin
				sda_low_q <= 1'b0;
			end
		end
	end

	// pins are open drain: output level fixed low, enable low pulls the line
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			SCL_OUT      <= 1'b0;
			SDA_OUT      <= 1'b0;
			SCL_OE_N_OUT <= 1'b1;
			SDA_OE_N_OUT <= 1'b1;
		end else begin
			SCL_OUT      <= 1'b0;
			SDA_OUT      <= 1'b0;
			SCL_OE_N_OUT <= ~scl_low_q;
			SDA_OE_N_OUT <= ~sda_low_q;
		end
	end

endmodule : sbmc_top

// ---- testbench/sbmc_bus_partner.sv ----
/* partner: pulled-up two-wire bus, a target that may stretch the clock,
   and a clock source for slave frames; assumes open-drain enables */
`timescale 1ns/1ps
module sbmc_bus_partner (
	// clock
	input  wire logic       clk_in,
	// enables from the block, low while driving
	input  wire logic       scl_oe_n_in,
	input  wire logic       sda_oe_n_in,
	// clock stretch after each release
	input  wire logic [3:0] stretch_in,
	// resolved wires
	output logic            scl_out,
	output logic            sda_out
);
	logic [3:0] hold_q = 4'h0;
	logic       oe_q = 1'b1;
	logic       gen_low = 1'b0;
	always_ff @(posedge clk_in) begin
		oe_q <= scl_oe_n_in;
		if (scl_oe_n_in && !oe_q) hold_q <= stretch_in;
		else if (hold_q != 4'h0) hold_q <= hold_q - 4'h1;
	end
	// a release always costs one cycle, like a slow rise
	assign scl_out = scl_oe_n_in && oe_q && hold_q == 4'h0 && !gen_low;
	assign sda_out = sda_oe_n_in;
	// clock only within the frame, idle high between frames
	task automatic clock_frame(input int n);
		#7;
		for (int i = 0; i < n; i++) begin
			gen_low = 1'b1;
			#160;
			gen_low = 1'b0;
			#160;
		end
	endtask : clock_frame
endmodule : sbmc_bus_partner

// ---- testbench/sbmc_top_asserts.sv ----
/* checker: bus handshakes, mode readback and clock-low bound of sbmc_top
   assumes it is bound to sbmc_top and sees only its ports */
`timescale 1ns/1ps
`include "sbmc_consts.svh"
module sbmc_top_asserts (
	// clock and reset
	input wire logic        CLK_IN,
	input wire logic        RST_IN,
	// register bus
	input wire logic        AXI_AWVALID_IN,
	input wire logic        AXI_AWREADY_OUT,
	input wire logic        AXI_WVALID_IN,
	input wire logic        AXI_WREADY_OUT,
	input wire logic        AXI_BVALID_OUT,
	input wire logic [31:0] AXI_ARADDR_IN,
	input wire logic        AXI_ARVALID_IN,
	input wire logic        AXI_ARREADY_OUT,
	input wire logic [31:0] AXI_RDATA_OUT,
	input wire logic [1:0]  AXI_RRESP_OUT,
	input wire logic        AXI_RVALID_OUT,
	input wire logic        AXI_RREADY_IN,
	// pins
	input wire logic        SCL_OUT,
	input wire logic        SCL_OE_N_OUT,
	input wire logic        SDA_OUT
);
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (RST_IN);
	logic [31:0] rd_addr_q;
	logic [4:0]  low_cnt_q;
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) rd_addr_q <= 32'h0;
		else if (AXI_ARVALID_IN && AXI_ARREADY_OUT) rd_addr_q <= AXI_ARADDR_IN;
	end
	// saturates, so a clock stuck low still trips the bound
	always_ff @(posedge CLK_IN) begin
		if (RST_IN || SCL_OE_N_OUT) low_cnt_q <= 5'h0;
		else if (low_cnt_q != 5'h1f) low_cnt_q <= low_cnt_q + 5'h1;
	end
	property p_rsv_ones;
		AXI_RVALID_OUT && rd_addr_q == `SBMC_ADDR_MODE |-> AXI_RDATA_OUT[5:4] == 2'h3;
	endproperty
	a_rsv_ones: assert property (p_rsv_ones) else $error("mode reserved bits not 1");
	property p_prot_one;
		AXI_RVALID_OUT && rd_addr_q == `SBMC_ADDR_MODE |-> AXI_RDATA_OUT[3];
	endproperty
	a_prot_one: assert property (p_prot_one) else $error("protect bit not 1");
	property p_unmapped;
		AXI_RVALID_OUT && rd_addr_q > `SBMC_ADDR_STAT
			|-> AXI_RRESP_OUT == `SBMC_RESP_SLVERR && AXI_RDATA_OUT == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
	property p_low_bound;
		!SCL_OE_N_OUT |-> low_cnt_q < 5'h17;
	endproperty
	a_low_bound: assert property (p_low_bound) else $error("clock low too long");
	property p_aw_refused;
		AXI_AWVALID_IN && AXI_AWREADY_OUT |=> !AXI_AWREADY_OUT;
	endproperty
	a_aw_refused: assert property (p_aw_refused) else $error("awready not dropped");
	property p_b_answer;
		AXI_AWVALID_IN && AXI_AWREADY_OUT && AXI_WVALID_IN && AXI_WREADY_OUT
			|-> ##2 AXI_BVALID_OUT;
	endproperty
	a_b_answer: assert property (p_b_answer) else $error("write response late");
	property p_r_answer;
		AXI_ARVALID_IN && AXI_ARREADY_OUT |=> AXI_RVALID_OUT && !AXI_ARREADY_OUT;
	endproperty
	a_r_answer: assert property (p_r_answer) else $error("read answer late");
	property p_r_clear;
		AXI_RVALID_OUT && AXI_RREADY_IN |=> !AXI_RVALID_OUT;
	endproperty
	a_r_clear: assert property (p_r_clear) else $error("rvalid not cleared");
	property p_open_drain;
		!SCL_OUT && !SDA_OUT;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("pin driven high");
endmodule : sbmc_top_asserts
bind sbmc_top sbmc_top_asserts u_asserts (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
	.AXI_AWVALID_IN(AXI_AWVALID_IN), .AXI_AWREADY_OUT(AXI_AWREADY_OUT),
	.AXI_WVALID_IN(AXI_WVALID_IN), .AXI_WREADY_OUT(AXI_WREADY_OUT),
	.AXI_BVALID_OUT(AXI_BVALID_OUT), .AXI_ARADDR_IN(AXI_ARADDR_IN),
	.AXI_ARVALID_IN(AXI_ARVALID_IN), .AXI_ARREADY_OUT(AXI_ARREADY_OUT),
	.AXI_RDATA_OUT(AXI_RDATA_OUT), .AXI_RRESP_OUT(AXI_RRESP_OUT),
	.AXI_RVALID_OUT(AXI_RVALID_OUT), .AXI_RREADY_IN(AXI_RREADY_IN),
	.SCL_OUT(SCL_OUT), .SCL_OE_N_OUT(SCL_OE_N_OUT), .SDA_OUT(SDA_OUT));

// ---- testbench/serial_bus_mode_control_test.sv ----
/* bench: register and frame tests of sbmc_top over axi4-lite
   assumes sbmc_bus_partner on the pins and the consts header */
`timescale 1ns/1ps
`include "sbmc_consts.svh"
module serial_bus_mode_control_test;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [31:0] awaddr = 32'h0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] araddr = 32'h0;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        arvalid = 1'b0;
	logic [3:0]  stretch = 4'h0;
	logic [31:0] rd;
	logic [1:0]  resp;
	logic [8:0]  cap = 9'h0;
	logic        scl_p = 1'b1;
	wire         awready, wready, bvalid, arready, rvalid, scl_oe_n, sda_oe_n, scl_w, sda_w;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	int          mismatches = 0, compares = 0, low_run = 0, max_low = 0, nrise = 0, d0 = 0;
	always #20 clk = ~clk;
	sbmc_top u_dut (.CLK_IN(clk), .RST_IN(rst), .AXI_AWADDR_IN(awaddr), .AXI_AWVALID_IN(awvalid),
		.AXI_AWREADY_OUT(awready), .AXI_WDATA_IN(wdata), .AXI_WSTRB_IN(4'h1),
		.AXI_WVALID_IN(wvalid), .AXI_WREADY_OUT(wready), .AXI_BRESP_OUT(bresp),
		.AXI_BVALID_OUT(bvalid), .AXI_BREADY_IN(1'b1), .AXI_ARADDR_IN(araddr),
		.AXI_ARVALID_IN(arvalid), .AXI_ARREADY_OUT(arready), .AXI_RDATA_OUT(rdata),
		.AXI_RRESP_OUT(rresp), .AXI_RVALID_OUT(rvalid), .AXI_RREADY_IN(1'b1), .SCL_IN(scl_w),
		.SCL_OUT(), .SCL_OE_N_OUT(scl_oe_n), .SDA_IN(sda_w), .SDA_OUT(),
		.SDA_OE_N_OUT(sda_oe_n));
	sbmc_bus_partner u_partner (.clk_in(clk), .scl_oe_n_in(scl_oe_n), .sda_oe_n_in(sda_oe_n),
		.stretch_in(stretch), .scl_out(scl_w), .sda_out(sda_w));
	// wire monitor: bits at clock rises, longest low run of the clock
	always @(posedge clk) begin
		scl_p <= scl_w;
		if (scl_w && !scl_p) cap <= {cap[7:0], sda_w};
		if (scl_w && !scl_p) nrise <= nrise + 1;
		low_run <= scl_w ? 0 : low_run + 1;
		if (low_run > max_low) max_low <= low_run;
	end
	task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask : check
	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge clk);
			if (awready && awvalid) awvalid <= 1'b0;
			if (wready && wvalid) wvalid <= 1'b0;
		end while (!bvalid);
		check("bresp", {30'h0, er}, {30'h0, bresp});
	endtask : wr
	task automatic rdx(input logic [31:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rd = rdata;
		resp = rresp;
	endtask : rdx
	task automatic rd_chk(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
		rdx(a);
		check("rdata", e, rd);
		check("rresp", {30'h0, er}, {30'h0, resp});
	endtask : rd_chk
	// start a frame and poll busy; a hang is left to the watchdog
	task automatic frame(input logic [7:0] ctl);
		max_low = 0;
		nrise = 0;
		wr(`SBMC_ADDR_CTRL, {24'h0, ctl}, `SBMC_RESP_OKAY);
		do rdx(`SBMC_ADDR_STAT); while (rd[8] !== 1'b0);
	endtask : frame
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : end_of_test
	initial begin
		#2000000;
		mismatches++;
		end_of_test();
	end
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd_chk(`SBMC_ADDR_MODE, 32'h38, `SBMC_RESP_OKAY);
		wr(`SBMC_ADDR_MODE, 32'hff, `SBMC_RESP_OKAY);
		rd_chk(`SBMC_ADDR_MODE, 32'hf8, `SBMC_RESP_OKAY);
		wr(`SBMC_ADDR_MODE, 32'h05, `SBMC_RESP_OKAY);
		rd_chk(`SBMC_ADDR_MODE, 32'h3d, `SBMC_RESP_OKAY);
		wr(`SBMC_ADDR_MODE, 32'h0a, `SBMC_RESP_OKAY);
		rd_chk(`SBMC_ADDR_MODE, 32'h3d, `SBMC_RESP_OKAY);
		wr(32'h10, 32'h0, `SBMC_RESP_SLVERR);
		rd_chk(32'h10, 32'h0, `SBMC_RESP_SLVERR);
		// two-wire master, one data bit and ack, slow target
		stretch <= 4'h3;
		wr(`SBMC_ADDR_TXD, 32'h0, `SBMC_RESP_OKAY);
		for (int w = 0; w < 2; w++) begin
			wr(`SBMC_ADDR_MODE, w ? 32'h41 : 32'h01, `SBMC_RESP_OKAY);
			frame(8'h06);
			check("bits", 32'h2, nrise);
			check("ack", 32'h1, {30'h0, cap[1:0]});
			rd_chk(`SBMC_ADDR_MODE, w ? 32'h78 : 32'h38, `SBMC_RESP_OKAY);
			if (w == 0) d0 = max_low;
		end
		check("wait", 2 * `SBMC_TCLK_CYC, max_low - d0);
		// synchronous master, both bit orders, wait set in the second
		stretch <= 4'h0;
		wr(`SBMC_ADDR_TXD, 32'hc1, `SBMC_RESP_OKAY);
		for (int w = 0; w < 2; w++) begin
			wr(`SBMC_ADDR_MODE, w ? 32'hc8 : 32'h08, `SBMC_RESP_OKAY);
			frame(8'h07);
			check("bits", 32'h8, nrise);
			check("order", w ? 32'h83 : 32'hc1, {24'h0, cap[7:0]});
			if (w == 0) d0 = max_low;
		end
		check("sync wait", d0, max_low);
		// two-wire slave with wait set, clocked by the partner
		wr(`SBMC_ADDR_TXD, 32'hff, `SBMC_RESP_OKAY);
		wr(`SBMC_ADDR_MODE, 32'h41, `SBMC_RESP_OKAY);
		wr(`SBMC_ADDR_CTRL, 32'h4, `SBMC_RESP_OKAY);
		// slave sits before its first clock: two bits left reads as code 001
		rd_chk(`SBMC_ADDR_MODE, 32'h79, `SBMC_RESP_OKAY);
		max_low = 0;
		u_partner.clock_frame(2);
		repeat (8) @(posedge clk);
		check("slave low", `SBMC_HALF_CYC, max_low);
		rd_chk(`SBMC_ADDR_MODE, 32'h78, `SBMC_RESP_OKAY);
		end_of_test();
	end
endmodule : serial_bus_mode_control_test
